// ---- rtl/rtc_flags_pkg.sv ----
// Constants, register map and carrier types of the real-time counter flag/status slice.
// Assumes an APB master with 32-bit data; every register occupies one aligned word.
package rtc_flags_pkg;

  // ---------------------------------------------------------------
  // Register indices (printed offsets); byte address is four times
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_ENCLR = 8'h06;
  localparam logic [7:0] IDX_ENSET = 8'h07;
  localparam logic [7:0] IDX_FLAGS = 8'h08;
  localparam logic [7:0] IDX_STATUS = 8'h0A;
  localparam logic [7:0] IDX_DBG = 8'h0B;
  localparam logic [7:0] IDX_TRIM = 8'h0C;
  localparam logic [7:0] IDX_COUNT = 8'h10;
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_COMP0 = 8'h18;
  localparam logic [7:0] IDX_COMP1 = 8'h19;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_WRAP = 7;
  localparam int BIT_SYNC_DONE = 6;
  localparam int BIT_MATCH1 = 1;
  localparam int BIT_MATCH0 = 0;
  localparam int BIT_BUSY = 7;
  localparam int BIT_RUN_DBG = 0;
  localparam int BIT_TRIM_SIGN = 7;
  localparam int BIT_CTRL_ENABLE = 1;
  localparam int BIT_CTRL_SWRST = 0;
  localparam int BIT_CTRL_MCLR = 7;
  localparam int POS_CTRL_MODE = 2;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [7:0] FLAG_MASK = 8'hC3;
  localparam int TRIM_PERIOD = 128;
  localparam int SYNC_CYCLES = 2;

  typedef enum logic [1:0] {
    MODE_COUNT32 = 2'b00,
    MODE_COUNT16 = 2'b01,
    MODE_CALENDAR = 2'b10
  } mode_type;

  typedef struct packed {
    logic sign;
    logic [6:0] value;
  } trim_type;

  typedef struct packed {
    logic clear_on_match;
    mode_type mode;
    logic enable;
    logic swrst;
  } ctrl_type;

endpackage

// ---- rtl/rtc_flags_status_count.sv ----
// Real-time counter slice: flags, enables, busy status, debug halt, rate trim and counter over APB.
// Assumes sys_clk runs the register side; counter_clock_tick marks each counter-clock cycle.
//
// Summary of operation
// - Counter overflow sets wrap flag bit 7
// - Writing one clears flag; zero no effect
// - Set flag with enable raises interrupt
// - Busy fall sets sync done, except enable/reset
// - 32-bit mode match sets match0 flag
// - 16-bit mode has two match flags
// - Calendar alarm match sets alarm flag
// - Busy bit tracks register synchronization
// - Counter halts in debug unless run bit
// - Run bit survives software reset
// - Trim sign selects correction direction
// - Trim magnitude scales correction; zero disables
// - Count register full 32-bit read/write
// - Enable set/clear views, ones act only
// - 32-bit mode match clears counter when clear_on_match set
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module rtc_flags_status_count
  import rtc_flags_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Counter time base and system state
  input wire logic counter_clock_tick,
  input wire logic debug_mode,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic setup_ok;
  logic access_ok;
  logic wr_en;
  logic [7:0] idx;
  logic mapped;
  logic wr_flags;
  logic wr_enclr;
  logic wr_enset;
  logic wr_dbg;
  logic wr_trim;
  logic wr_count;
  logic wr_ctrl;
  logic wr_comp0;
  logic wr_comp1;

  // Registers answer with no wait state: setup, then access with pready high
  assign setup_ok = psel & ~penable;
  assign access_ok = psel & penable & pready;
  assign wr_en = access_ok & pwrite;
  assign idx = 8'(paddr >> 2);

  // One decode of the index gives both the write strobes and the map check, so they cannot disagree
  always_comb begin
    mapped = 1'b1;
    wr_flags = 1'b0;
    wr_enclr = 1'b0;
    wr_enset = 1'b0;
    wr_dbg = 1'b0;
    wr_trim = 1'b0;
    wr_count = 1'b0;
    wr_ctrl = 1'b0;
    wr_comp0 = 1'b0;
    wr_comp1 = 1'b0;
    unique case (idx)
      IDX_FLAGS: begin
        wr_flags = wr_en;
      end
      IDX_ENCLR: begin
        wr_enclr = wr_en;
      end
      IDX_ENSET: begin
        wr_enset = wr_en;
      end
      IDX_DBG: begin
        wr_dbg = wr_en;
      end
      IDX_TRIM: begin
        wr_trim = wr_en;
      end
      IDX_COUNT: begin
        wr_count = wr_en;
      end
      IDX_CTRL: begin
        wr_ctrl = wr_en;
      end
      IDX_COMP0: begin
        wr_comp0 = wr_en;
      end
      IDX_COMP1: begin
        wr_comp1 = wr_en;
      end
      IDX_STATUS: begin
        mapped = 1'b1; // Read only: a write is accepted and ignored
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  ctrl_type ctrl_ff;
  trim_type trim_ff;
  logic run_in_debug_ff;
  logic [7:0] irq_enable_ff;
  logic [7:0] irq_flags_ff;
  logic [31:0] count_ff;
  logic [31:0] comp0_ff;
  logic [15:0] comp1_ff;
  logic [31:0] alarm_ff;
  logic sync_in_progress_ff;
  logic [1:0] sync_cnt_ff;
  logic sync_quiet_ff;
  logic [6:0] trim_phase_ff;
  logic swrst_now;

  assign swrst_now = wr_ctrl & pwdata[BIT_CTRL_SWRST];

  always_ff @(posedge sys_clk) begin
    if (sys_rst || swrst_now) begin
      ctrl_ff <= '0;
    end else if (wr_ctrl) begin
      ctrl_ff.clear_on_match <= pwdata[BIT_CTRL_MCLR];
      ctrl_ff.mode <= mode_type'(pwdata[POS_CTRL_MODE +: 2]);
      ctrl_ff.enable <= pwdata[BIT_CTRL_ENABLE];
      ctrl_ff.swrst <= 1'b0;
    end
  end

  // Software reset leaves it; only a full reset or a write of zero clears it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_in_debug_ff <= 1'b0;
    end else if (wr_dbg) begin
      run_in_debug_ff <= pwdata[BIT_RUN_DBG];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || swrst_now) begin
      trim_ff <= trim_type'(RST_BYTE);
    end else if (wr_trim) begin
      trim_ff <= trim_type'(pwdata[7:0]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || swrst_now) begin
      irq_enable_ff <= RST_BYTE;
    end else if (wr_enset) begin
      irq_enable_ff <= irq_enable_ff | (pwdata[7:0] & FLAG_MASK);
    end else if (wr_enclr) begin
      irq_enable_ff <= irq_enable_ff & ~pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || swrst_now) begin
      comp0_ff <= RST_WORD;
      comp1_ff <= RST_WORD[15:0];
      alarm_ff <= RST_WORD;
    end else begin
      if (wr_comp0) begin
        comp0_ff <= pwdata;
        alarm_ff <= pwdata;
      end
      if (wr_comp1) begin
        comp1_ff <= pwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Synchronization busy
  // ---------------------------------------------------------------
  // Writes to synchronized registers hold busy for a fixed crossing time
  logic sync_start;
  logic quiet_start;
  assign sync_start = wr_count | wr_trim | wr_ctrl | wr_comp0 | wr_comp1;
  // Enabling or resetting runs the same window, but its end must not raise sync done
  assign quiet_start = wr_ctrl & (pwdata[BIT_CTRL_SWRST] | (pwdata[BIT_CTRL_ENABLE] & ~ctrl_ff.enable));

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_in_progress_ff <= 1'b0;
      sync_cnt_ff <= 2'h0;
      sync_quiet_ff <= 1'b0;
    end else if (sync_start) begin
      sync_in_progress_ff <= 1'b1;
      sync_cnt_ff <= 2'(SYNC_CYCLES);
      sync_quiet_ff <= quiet_start;
    end else if (sync_cnt_ff != 2'h0) begin
      sync_cnt_ff <= sync_cnt_ff - 2'h1;
      if (sync_cnt_ff == 2'h1) begin
        sync_in_progress_ff <= 1'b0;
      end
    end
  end

  logic sync_done_evt;
  assign sync_done_evt = sync_in_progress_ff & (sync_cnt_ff == 2'h1) & ~sync_start & ~sync_quiet_ff;

  // ---------------------------------------------------------------
  // Rate trim and counting
  // ---------------------------------------------------------------
  // A tick is dropped (sign 0) or doubled (sign 1) VALUE times in every 128 ticks
  logic halted;
  logic tick;
  logic trim_hit;
  logic [1:0] step;
  logic [31:0] cnt_next;
  logic wrap_evt;
  logic [31:0] wrap_top;

  assign halted = debug_mode & ~run_in_debug_ff;
  assign tick = ctrl_ff.enable & counter_clock_tick & ~halted;
  assign trim_hit = (trim_ff.value != 7'h00) & (trim_phase_ff < trim_ff.value);

  always_comb begin
    step = 2'h1;
    if (trim_hit) begin
      step = trim_ff.sign ? 2'h2 : 2'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || swrst_now) begin
      trim_phase_ff <= 7'h00;
    end else if (tick) begin
      trim_phase_ff <= trim_phase_ff + 7'h01;
    end
  end

  logic match0;
  logic match1;

  // The unused mode code counts and matches as the 32-bit counter, but never clears on match
  always_comb begin
    match0 = 1'b0;
    match1 = 1'b0;
    wrap_top = 32'hFFFFFFFF;
    unique case (ctrl_ff.mode)
      MODE_COUNT16: begin
        wrap_top = 32'h0000FFFF;
        match0 = (count_ff[15:0] == comp0_ff[15:0]);
        match1 = (count_ff[15:0] == comp1_ff);
      end
      MODE_CALENDAR: begin
        match0 = (count_ff == alarm_ff);
      end
      default: begin
        match0 = (count_ff == comp0_ff);
      end
    endcase
  end

  always_comb begin
    cnt_next = count_ff + {30'h0, step};
    wrap_evt = tick & (step != 2'h0) & (count_ff > wrap_top - {30'h0, step});
    if (wrap_evt) begin
      cnt_next = 32'(count_ff + {30'h0, step} - wrap_top - 32'h1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || swrst_now) begin
      count_ff <= RST_WORD;
    end else if (wr_count) begin
      count_ff <= pwdata;
    end else if (tick) begin
      if (match0 && ctrl_ff.clear_on_match && ctrl_ff.mode == MODE_COUNT32) begin
        count_ff <= RST_WORD;
      end else begin
        count_ff <= cnt_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // Flags and interrupt
  // ---------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb begin
    flag_set = 8'h00;
    flag_set[BIT_WRAP] = wrap_evt;
    flag_set[BIT_SYNC_DONE] = sync_done_evt;
    flag_set[BIT_MATCH0] = tick & match0;
    flag_set[BIT_MATCH1] = tick & match1;
    flag_clr = wr_flags ? pwdata[7:0] : 8'h00;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || swrst_now) begin
      irq_flags_ff <= RST_BYTE;
    end else begin
      irq_flags_ff <= ((irq_flags_ff & ~flag_clr) | flag_set) & FLAG_MASK;
    end
  end

  // Registered output: one cycle of lag is traded for a glitch-free request line
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_flags_ff & irq_enable_ff);
    end
  end

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [7:0] ctrl_view;
  logic [7:0] status_view;

  // Software reset is self-clearing, so it always reads back as zero
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[BIT_CTRL_MCLR] = ctrl_ff.clear_on_match;
    ctrl_view[POS_CTRL_MODE +: 2] = ctrl_ff.mode;
    ctrl_view[BIT_CTRL_ENABLE] = ctrl_ff.enable;
    status_view = 8'h00;
    status_view[BIT_BUSY] = sync_in_progress_ff;
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (idx)
      IDX_ENCLR, IDX_ENSET: rd_mux = {24'h0, irq_enable_ff};
      IDX_FLAGS: rd_mux = {24'h0, irq_flags_ff};
      IDX_STATUS: rd_mux = {24'h0, status_view};
      IDX_DBG: rd_mux = {31'h0, run_in_debug_ff};
      IDX_TRIM: rd_mux = {24'h0, trim_ff};
      IDX_COUNT: rd_mux = count_ff;
      IDX_CTRL: rd_mux = {24'h0, ctrl_view};
      IDX_COMP0: rd_mux = comp0_ff;
      IDX_COMP1: rd_mux = {16'h0, comp1_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      // Every access is answered in the cycle right after its setup
      pready <= setup_ok;
      pslverr <= setup_ok & ~mapped;
      prdata <= (setup_ok & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

endmodule // rtc_flags_status_count

// ---- verification/rtc_flags_status_count_props.sv ----
// Checker of the counter slice: APB answer, read masks, refusal of unmapped places, interrupt clear.
// Assumes the bind below and byte addresses of four times the register index.
`timescale 1ns/1ps
module rtc_flags_status_count_props
  import rtc_flags_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // APB and interrupt
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] idx;
  logic acc;
  logic rd;
  logic mapped;
  assign idx = 8'(paddr >> 2);
  assign acc = psel && penable && pready;
  assign rd = acc && !pwrite;
  assign mapped = idx inside {IDX_CTRL, IDX_ENCLR, IDX_ENSET, IDX_FLAGS, IDX_STATUS, IDX_DBG, IDX_TRIM, IDX_COUNT,
                              IDX_COMP0, IDX_COMP1};
  AST_READY_ONE: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable)) else $error("answer without setup");
  AST_ERR_UNMAPPED: assert property (acc |-> pslverr == !mapped) else $error("error flag wrong for address");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h00000000) else $error("read data outside access");
  AST_FLAG_BITS: assert property (rd && idx == IDX_FLAGS |-> (prdata & ~{24'h000000, FLAG_MASK}) == 32'h0)
    else $error("flag read shows unused bits");
  AST_STATUS_BITS: assert property (rd && idx == IDX_STATUS |-> prdata[31:8] == 24'h0 && prdata[6:0] == 7'h00)
    else $error("status read shows bits other than busy");
  AST_DBG_BITS: assert property (rd && idx == IDX_DBG |-> prdata[31:1] == 31'h0)
    else $error("debug control shows unused bits");
  AST_IRQ_CLEAR: assert property (acc && pwrite && idx == IDX_ENCLR && (pwdata[7:0] & FLAG_MASK) == FLAG_MASK
    |-> ##2 !irq[*2]) else $error("interrupt still high after all enables cleared");
  cover property (rd && idx == IDX_FLAGS && prdata[BIT_WRAP]);
  cover property (acc && pslverr);
  cover property ($rose(irq));
endmodule // rtc_flags_status_count_props

bind rtc_flags_status_count rtc_flags_status_count_props #(.ADDR_WIDTH(ADDR_WIDTH)) i_props (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// ---- verification/test_rtc_flags_status_count.sv ----
// Self-checking bench of the counter slice, driven through APB tasks and counter-clock ticks.
// Assumes the package constants and the zero-wait-state APB answer of the design.
`timescale 1ns/1ps
module test_rtc_flags_status_count;
  import rtc_flags_pkg::*;
  logic sys_clk, sys_rst, counter_clock_tick, debug_mode, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, got;
  logic got_err;
  int err_count = 0;
  int n_checks = 0;
  always #25 sys_clk = ~sys_clk;
  rtc_flags_status_count i_rtc_flags_status_count (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .counter_clock_tick(counter_clock_tick), .debug_mode(debug_mode), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // -----------------------------
  // Bus and tick tasks
  // -----------------------------
  // Three idle cycles after each wr and rd transfer let the busy window and irq lag pass
  // A gap of zero keeps psel high so the next setup follows the access at once
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input int gap);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      conclude();
    end
    got = prdata;
    got_err = pslverr;
    if (gap > 0) begin
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (gap) @(posedge sys_clk);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd, 3);
  endtask
  task automatic wr_b2b(input logic [7:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd, 0);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
    xfer(1'b0, idx, 32'h00000000, 3);
    n_checks++;
    if (got !== exp || got_err !== exp_err) begin
      err_count++;
      $display("[FAIL] reg %h expected %h/%b seen %h/%b", idx, exp, exp_err, got, got_err);
    end
  endtask
  task automatic chk_irq(input logic exp);
    n_checks++;
    if (irq !== exp) begin
      err_count++;
      $display("[FAIL] irq expected %b seen %b", exp, irq);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      counter_clock_tick <= 1'b1;
      @(posedge sys_clk);
    end
    counter_clock_tick <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    {counter_clock_tick, debug_mode, psel, penable, pwrite} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(IDX_FLAGS, 32'h00, 1'b0);
    rd(IDX_STATUS, 32'h00, 1'b0);
    rd(IDX_DBG, 32'h00, 1'b0);
    rd(IDX_TRIM, 32'h00, 1'b0);
    rd(8'h01, 32'h00, 1'b1);
    wr(IDX_COUNT, 32'hFFFFFFFE);
    rd(IDX_COUNT, 32'hFFFFFFFE, 1'b0);
    rd(IDX_FLAGS, 32'h40, 1'b0);
    wr(IDX_FLAGS, 32'h00);
    rd(IDX_FLAGS, 32'h40, 1'b0);
    wr(IDX_COMP0, 32'h05);
    wr(IDX_FLAGS, 32'hFF);
    wr(IDX_CTRL, 32'h02);
    rd(IDX_FLAGS, 32'h00, 1'b0);
    ticks(2);
    rd(IDX_FLAGS, 32'h80, 1'b0);
    ticks(6);
    rd(IDX_FLAGS, 32'h81, 1'b0);
    chk_irq(1'b0);
    wr(IDX_ENSET, 32'h01);
    chk_irq(1'b1);
    wr(IDX_ENCLR, 32'hFF);
    chk_irq(1'b0);
    wr(IDX_ENSET, 32'h80);
    chk_irq(1'b1);
    wr(IDX_FLAGS, 32'h80);
    chk_irq(1'b0);
    debug_mode <= 1'b1;
    ticks(3);
    rd(IDX_COUNT, 32'h06, 1'b0);
    wr(IDX_DBG, 32'h01);
    ticks(3);
    rd(IDX_COUNT, 32'h09, 1'b0);
    debug_mode <= 1'b0;
    wr(IDX_CTRL, 32'h01);
    rd(IDX_DBG, 32'h01, 1'b0);
    rd(IDX_FLAGS, 32'h00, 1'b0);
    // A full trim period of 128 ticks makes the count independent of the trim phase
    wr(IDX_CTRL, 32'h02);
    wr(IDX_TRIM, 32'h8A);
    rd(IDX_TRIM, 32'h8A, 1'b0);
    wr(IDX_COUNT, 32'h00);
    ticks(TRIM_PERIOD);
    rd(IDX_COUNT, 32'(TRIM_PERIOD + 10), 1'b0);
    wr(IDX_TRIM, 32'h0A);
    wr(IDX_COUNT, 32'h00);
    ticks(TRIM_PERIOD);
    rd(IDX_COUNT, 32'(TRIM_PERIOD - 10), 1'b0);
    wr(IDX_CTRL, 32'h01);
    wr(IDX_COMP1, 32'h02);
    wr(IDX_CTRL, 32'h06);
    wr(IDX_FLAGS, 32'hFF);
    ticks(3);
    rd(IDX_FLAGS, 32'h03, 1'b0);
    wr(IDX_CTRL, 32'h01);
    wr(IDX_COMP0, 32'h01);
    wr(IDX_CTRL, 32'h0A);
    wr(IDX_FLAGS, 32'hFF);
    ticks(2);
    rd(IDX_FLAGS, 32'h01, 1'b0);
    // The flag clear lands on the very edge at which the busy window ends
    wr_b2b(IDX_TRIM, 32'h00);
    wr(IDX_FLAGS, 32'h40);
    rd(IDX_FLAGS, 32'h41, 1'b0);
    wr(IDX_CTRL, 32'h01);
    wr(IDX_COMP0, 32'h03);
    wr(IDX_CTRL, 32'h82);
    wr(IDX_FLAGS, 32'hFF);
    ticks(6);
    rd(IDX_COUNT, 32'h02, 1'b0);
    rd(IDX_FLAGS, 32'h01, 1'b0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk_irq(1'b0);
    rd(IDX_DBG, 32'h00, 1'b0);
    rd(IDX_COUNT, 32'h00, 1'b0);
    conclude();
  end
endmodule // test_rtc_flags_status_count
